/* logic/rfc_pkg.sv */
// constants, types and helpers of the resistance frequency unit
package rfc_pkg;

  // register offsets
  localparam logic [7:0] REG_TIMER0_CONTROL = 8'h01;
  localparam logic [7:0] REG_NETWORK        = 8'h2f;
  localparam logic [7:0] REG_TIMER_ENABLE   = 8'h30;
  localparam logic [7:0] REG_IRQ_ENABLE     = 8'h31;
  localparam logic [7:0] REG_T0_DATA        = 8'h32;
  localparam logic [7:0] REG_T1_DATA        = 8'h33;
  localparam logic [7:0] REG_T2_DATA        = 8'h34;
  localparam logic [7:0] REG_WINDOW_TIMER   = 8'h35;
  localparam logic [7:0] REG_STATUS         = 8'h36;

  // field positions
  localparam int STOP_MODE_LO  = 6;
  localparam int NET_SEL_LO    = 4;
  localparam int EN_T0_BIT     = 0;
  localparam int EN_T1_BIT     = 1;
  localparam int EN_T2_BIT     = 2;
  localparam int IRQ_T0_BIT    = 2;
  localparam int ST_STOP_BIT   = 0;
  localparam int ST_WINDOW_BIT = 1;

  // reset values and counts
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [7:0] WINDOW_SKIP = 8'h02;
  localparam logic [7:0] WINDOW_ONE  = 8'h01;
  localparam logic [7:0] WINDOW_ZERO = 8'h00;

  typedef enum logic [1:0] {
    NET_OFF  = 2'h0,
    NET_REF  = 2'h1,
    NET_TEMP = 2'h2,
    NET_HUM  = 2'h3
  } rfc_net_e;

  typedef enum logic [1:0] {
    STOP_OFF = 2'h0,
    STOP_OVF = 2'h1,
    STOP_OSC = 2'h2,
    STOP_WIN = 2'h3
  } rfc_stop_e;

  typedef enum logic [1:0] {
    WID_8  = 2'h0,
    WID_16 = 2'h1,
    WID_24 = 2'h2
  } rfc_width_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ARM   = 4'h2,
    ST_COUNT = 4'h4,
    ST_DONE  = 4'h8
  } rfc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rfc_bus_s;

  // bits of the chained counter that take part at a given width
  function automatic logic [23:0] width_mask(input rfc_width_e w);
    logic [23:0] m;
    m = 24'h0000ff;
    if (w == WID_16) begin
      m = 24'h00ffff;
    end else if (w == WID_24) begin
      m = 24'hffffff;
    end
    return m;
  endfunction

endpackage

/* logic/rfc_sync.sv */
// two stage synchroniser with falling edge detect
`timescale 1ns/1ps
module rfc_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // asynchronous level
  input  wire logic d,
  // synchronised level and falling edge pulse
  output logic      q,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;
  logic next_s1;
  logic next_s2;
  logic next_s3;

  always_comb begin
    next_s1 = d;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  assign q    = s2;
  assign fall = s3 & ~s2;
endmodule

/* logic/rfc_counter.sv */
// chained 8/16/24 bit preloadable down counter
`timescale 1ns/1ps
module rfc_counter
  import rfc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // byte preload
  input  wire logic [2:0] load,
  input  wire logic [7:0] load_data,
  // count control
  input  wire logic       dec,
  input  rfc_width_e      width,
  // contents
  output logic [23:0]     value
);
  logic [23:0] next_value;
  logic [23:0] mask;

  always_comb begin
    mask       = width_mask(width);
    next_value = value;
    if (|load) begin
      for (int i = 0; i < 3; i++) begin
        if (load[i]) begin
          next_value[i*8 +: 8] = load_data;
        end
      end
    end else if (dec) begin
      next_value = (value & ~mask) | ((value - 24'h000001) & mask);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      value <= 24'h000000;
    end else begin
      value <= next_value;
    end
  end
endmodule

/* logic/rfc_top.sv */
// resistance frequency unit: network pins, window control and registers
`timescale 1ns/1ps
module rfc_top
  import rfc_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  resetn,
  // register port
  input  rfc_bus_s   bus,
  output logic [7:0] rdata,
  // oscillation and timer clocks
  input  wire logic  oscillation_input,
  input  wire logic  timer_zero_clock,
  input  wire logic  window_timer_clock,
  // network pins
  output logic       reference_resistor_out,
  output logic       reference_resistor_out_oe,
  output logic       temperature_sensor_out,
  output logic       temperature_sensor_out_oe,
  output logic       humidity_sensor_out,
  output logic       humidity_sensor_out_oe,
  // status
  output logic       stop_flag,
  output logic       counting_window,
  output logic       timer_zero_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic osc_q;
  logic osc_fall;
  logic t0clk_fall;
  logic win_fall;

  rfc_sync u_osc_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (oscillation_input),
    .q      (osc_q),
    .fall   (osc_fall)
  );

  rfc_sync u_t0clk_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (timer_zero_clock),
    .q      (),
    .fall   (t0clk_fall)
  );

  // enable is taken in the system domain, so the window may slip
  rfc_sync u_win_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (window_timer_clock),
    .q      (),
    .fall   (win_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] timer0_control;
  logic [7:0] infrared_and_network_control;
  logic [2:0] timer_enable;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] win_load;
  logic [7:0] next_timer0_control;
  logic [7:0] next_infrared_and_network_control;
  logic [2:0] next_timer_enable;
  logic [7:0] next_interrupt_enable_reg;
  logic [7:0] next_win_load;
  logic       wr_stop_clear;
  logic [2:0] data_load;

  rfc_stop_e  stop_mode;
  rfc_net_e   net_sel;
  logic       timer_zero_on;
  logic       timer_one_on;
  logic       window_timer_on;
  logic       timer_zero_irq_enable;

  assign stop_mode             = rfc_stop_e'(timer0_control[STOP_MODE_LO +: 2]);
  assign net_sel               = rfc_net_e'(infrared_and_network_control[NET_SEL_LO +: 2]);
  assign timer_zero_on         = timer_enable[EN_T0_BIT];
  assign timer_one_on          = timer_enable[EN_T1_BIT];
  assign window_timer_on       = timer_enable[EN_T2_BIT];
  assign timer_zero_irq_enable = interrupt_enable_reg[IRQ_T0_BIT];

  always_comb begin
    next_timer0_control               = timer0_control;
    next_infrared_and_network_control = infrared_and_network_control;
    next_timer_enable                 = timer_enable;
    next_interrupt_enable_reg         = interrupt_enable_reg;
    next_win_load                     = win_load;
    wr_stop_clear                     = 1'b0;
    data_load                         = 3'h0;
    if (bus.wr) begin
      unique case (bus.addr)
        REG_TIMER0_CONTROL: next_timer0_control = bus.wdata;
        REG_NETWORK:        next_infrared_and_network_control = bus.wdata;
        REG_TIMER_ENABLE:   next_timer_enable = bus.wdata[2:0];
        REG_IRQ_ENABLE:     next_interrupt_enable_reg = bus.wdata;
        REG_T0_DATA:        data_load = 3'h1;
        REG_T1_DATA:        data_load = 3'h2;
        REG_T2_DATA:        data_load = 3'h4;
        REG_WINDOW_TIMER:   next_win_load = bus.wdata;
        REG_STATUS:         wr_stop_clear = bus.wdata[ST_STOP_BIT];
        default:            data_load = 3'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer0_control               <= BYTE_RESET;
      infrared_and_network_control <= BYTE_RESET;
      timer_enable                 <= 3'h0;
      interrupt_enable_reg         <= BYTE_RESET;
      win_load                     <= BYTE_RESET;
    end else begin
      timer0_control               <= next_timer0_control;
      infrared_and_network_control <= next_infrared_and_network_control;
      timer_enable                 <= next_timer_enable;
      interrupt_enable_reg         <= next_interrupt_enable_reg;
      win_load                     <= next_win_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting window control
  rfc_state_e  state;
  rfc_state_e  next_state;
  logic [7:0]  win_cnt;
  logic [7:0]  next_win_cnt;
  logic        next_stop_flag;
  logic        next_counting_window;
  logic        next_timer_zero_irq;
  logic        start_ok;
  logic        end_evt;
  logic        count_edge;
  rfc_width_e  width;
  logic [23:0] count_value;

  always_comb begin
    // overflow mode needs window timer too and stays at 16 bits at most (8 without timer one)
    start_ok = timer_zero_on && (stop_mode != STOP_OVF || window_timer_on);
    width    = timer_one_on ? WID_16 : WID_8;
    if (timer_one_on && window_timer_on && (stop_mode == STOP_OSC || stop_mode == STOP_OFF)) begin
      width = WID_24;
    end
    // timer zero clock counts in cycle mode and with stop off, oscillation otherwise
    count_edge = (stop_mode == STOP_OSC || stop_mode == STOP_OFF) ? t0clk_fall : osc_fall;
    end_evt    = 1'b0;
    unique case (stop_mode)
      STOP_OVF: end_evt = (win_cnt == WINDOW_ZERO) || (win_fall && win_cnt == WINDOW_ONE);
      STOP_OSC: end_evt = osc_fall;
      STOP_WIN: end_evt = win_fall;
      STOP_OFF: end_evt = 1'b0;
    endcase
  end

  always_comb begin
    next_state     = state;
    next_win_cnt   = win_cnt;
    next_stop_flag = stop_flag;
    if (wr_stop_clear) begin
      next_stop_flag = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state     = ST_ARM;
          next_stop_flag = 1'b0; // re-enable starts afresh
        end
      end
      ST_ARM: begin
        if (stop_mode == STOP_OFF) begin
          next_state = ST_COUNT;
        end else if (stop_mode == STOP_OVF && win_fall) begin
          next_state   = ST_COUNT;
          // Y-2 decrements until zero
          next_win_cnt = (win_load > WINDOW_SKIP) ? win_load - WINDOW_SKIP : WINDOW_ZERO;
        end else if ((stop_mode == STOP_OSC && osc_fall) || (stop_mode == STOP_WIN && win_fall)) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (end_evt) begin
          next_state     = ST_DONE;
          next_stop_flag = 1'b1;
          next_win_cnt   = WINDOW_ZERO;
        end else if (stop_mode == STOP_OVF && win_fall) begin
          next_win_cnt = win_cnt - WINDOW_ONE;
        end
      end
      ST_DONE: begin
        // the flag holds here; only a status clear or a new start drops it
        next_state   = ST_DONE;
        next_win_cnt = WINDOW_ZERO;
      end
    endcase
    if (!start_ok) begin
      next_state = ST_IDLE;
      if (state == ST_COUNT && end_evt) begin
        next_stop_flag = 1'b1;
      end
    end
    next_counting_window = (next_state == ST_COUNT);
    next_timer_zero_irq  = next_stop_flag && timer_zero_irq_enable;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state           <= ST_IDLE;
      win_cnt         <= WINDOW_ZERO;
      stop_flag       <= 1'b0;
      counting_window <= 1'b0;
      timer_zero_irq  <= 1'b0;
    end else begin
      state           <= next_state;
      win_cnt         <= next_win_cnt;
      stop_flag       <= next_stop_flag;
      counting_window <= next_counting_window;
      timer_zero_irq  <= next_timer_zero_irq;
    end
  end

  // counter only counts inside the window; after stop only a preload write changes it
  rfc_counter u_counter (
    .clk       (clk),
    .resetn    (resetn),
    .load      (data_load),
    .load_data (bus.wdata),
    .dec       (state == ST_COUNT && count_edge),
    .width     (width),
    .value     (count_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // network pins and read data
  logic       next_ref_oe;
  logic       next_temp_oe;
  logic       next_hum_oe;
  logic [7:0] next_rdata;

  always_comb begin
    // only the selected network drives
    next_ref_oe  = (net_sel == NET_REF);
    next_temp_oe = (net_sel == NET_TEMP);
    next_hum_oe  = (net_sel == NET_HUM);
    next_rdata   = BYTE_RESET;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_TIMER0_CONTROL: next_rdata = timer0_control;
        REG_NETWORK:        next_rdata = infrared_and_network_control;
        REG_TIMER_ENABLE:   next_rdata = {5'h00, timer_enable};
        REG_IRQ_ENABLE:     next_rdata = interrupt_enable_reg;
        REG_T0_DATA:        next_rdata = count_value[7:0];
        REG_T1_DATA:        next_rdata = count_value[15:8];
        REG_T2_DATA:        next_rdata = count_value[23:16];
        REG_WINDOW_TIMER:   next_rdata = win_cnt;
        REG_STATUS:         next_rdata = {6'h00, counting_window, stop_flag};
        default:            next_rdata = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reference_resistor_out    <= 1'b0;
      reference_resistor_out_oe <= 1'b0;
      temperature_sensor_out    <= 1'b0;
      temperature_sensor_out_oe <= 1'b0;
      humidity_sensor_out       <= 1'b0;
      humidity_sensor_out_oe    <= 1'b0;
      rdata                     <= BYTE_RESET;
    end else begin
      reference_resistor_out    <= ~osc_q;
      reference_resistor_out_oe <= next_ref_oe;
      temperature_sensor_out    <= ~osc_q;
      temperature_sensor_out_oe <= next_temp_oe;
      humidity_sensor_out       <= ~osc_q;
      humidity_sensor_out_oe    <= next_hum_oe;
      rdata                     <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence osc_armed_s;
    state == ST_ARM && stop_mode == STOP_OSC && osc_fall && start_ok;
  endsequence
  sequence win_armed_s;
    state == ST_ARM && stop_mode == STOP_WIN && win_fall && start_ok;
  endsequence
  sequence window_open_s;
    state == ST_COUNT && counting_window;
  endsequence

  one_network_a: assert property (
    $onehot0({reference_resistor_out_oe, temperature_sensor_out_oe, humidity_sensor_out_oe}))
    else $error("more than one network pin enabled");
  network_select_a: assert property (
    ##1 temperature_sensor_out_oe == ($past(net_sel) == NET_TEMP))
    else $error("temperature pin enable does not follow select");
  inverse_drive_a: assert property (
    $past(resetn) |-> humidity_sensor_out == !$past(osc_q))
    else $error("network pin not inverse of oscillation input");
  count_step_a: assert property (
    state == ST_COUNT && count_edge && data_load == 3'h0 && start_ok
    |=> count_value[7:0] == $past(count_value[7:0]) - 8'h01)
    else $error("counter did not decrement on edge");
  narrow_hold_a: assert property (
    width == WID_8 && data_load == 3'h0 |=> count_value[23:8] == $past(count_value[23:8]))
    else $error("upper bytes moved in 8 bit width");
  window_only_a: assert property (
    data_load == 3'h0 && state != ST_COUNT |=> $stable(count_value))
    else $error("counter moved outside window");
  stop_set_a: assert property (
    state == ST_COUNT && end_evt |=> stop_flag && state != ST_COUNT)
    else $error("window end did not set stop flag");
  irq_gate_a: assert property (
    timer_zero_irq |-> $past(timer_zero_irq_enable))
    else $error("interrupt without enable bit");
  ovf_start_a: assert property (
    stop_mode == STOP_OVF && !window_timer_on |=> state == ST_IDLE)
    else $error("overflow mode started without window timer");
  window_dec_a: assert property (
    state == ST_COUNT && stop_mode == STOP_OVF && win_fall && win_cnt > WINDOW_ONE
    && start_ok |=> win_cnt == $past(win_cnt) - WINDOW_ONE)
    else $error("window timer did not step down");
  osc_cycle_a: assert property (
    osc_armed_s |=> window_open_s)
    else $error("oscillation edge did not open window");
  win_cycle_a: assert property (
    win_armed_s |=> window_open_s)
    else $error("window clock edge did not open window");
  final_hold_a: assert property (
    state == ST_DONE && data_load == 3'h0 |=> $stable(count_value))
    else $error("counter changed after stop");
endmodule

/* testbench/rfc_osc_model.sv */
// behavioural rc oscillator network hung on the three sensor pins
`timescale 1ns/1ps
module rfc_osc_model #(
  parameter int REF_HALF_NS  = 2000,
  parameter int TEMP_HALF_NS = 3000,
  parameter int HUM_HALF_NS  = 4400
) (
  // network pins of the unit
  input  wire logic ref_out,
  input  wire logic ref_oe,
  input  wire logic temp_out,
  input  wire logic temp_oe,
  input  wire logic hum_out,
  input  wire logic hum_oe,
  // capacitor node at the schmitt input
  output logic      cx
);
  logic [1:0] drivers;
  logic       lvl;
  int         half_ns;

  ////////////////////////////////////////////////////////////////////////////////
  // resolve the tri-state pins; a fight between two pins gives no usable level
  always_comb begin
    drivers = 2'(ref_oe) + 2'(temp_oe) + 2'(hum_oe);
    lvl     = ref_oe ? ref_out : (temp_oe ? temp_out : hum_out);
    if (drivers > 2'h1) lvl = 1'bx;
    half_ns = ref_oe ? REF_HALF_NS : (temp_oe ? TEMP_HALF_NS : HUM_HALF_NS);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capacitor charges toward the driven pin, leaks to ground when nothing drives
  initial begin
    cx = 1'b0;
    forever begin
      #10;
      if (drivers != 2'h0 && lvl !== cx) begin
        #(half_ns);
        if (drivers != 2'h0) cx = lvl;
      end else if (drivers == 2'h0) begin
        cx = 1'b0;
      end
    end
  end
endmodule

/* testbench/resistor_frequency_counter_tb_top.sv */
// self-checking bench of the resistance frequency unit
`timescale 1ns/1ps
module resistor_frequency_counter_tb_top
  import rfc_pkg::*;
();
  logic        clk, resetn, cx, t0_clk, win_clk;
  rfc_bus_s    bus;
  logic [7:0]  rdata;
  logic        ref_out, ref_oe, temp_out, temp_oe, hum_out, hum_oe;
  logic        stop_flag, counting_window, timer_zero_irq;
  int          miscompares, checks, n_t0, n_cx, n_win;

  ////////////////////////////////////////////////////////////////////////////////
  // clocks and edge counters inside the window
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    t0_clk = 1'b1;
    #7;
    forever #100 t0_clk = ~t0_clk;
  end
  initial begin
    win_clk = 1'b1;
    #13;
    forever #20000 win_clk = ~win_clk;
  end
  always @(negedge t0_clk) if (counting_window === 1'b1) n_t0++;
  always @(negedge cx) if (counting_window === 1'b1) n_cx++;
  always @(negedge win_clk) if (counting_window === 1'b1) n_win++;

  rfc_top rfc_top_i (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .oscillation_input(cx), .timer_zero_clock(t0_clk), .window_timer_clock(win_clk),
    .reference_resistor_out(ref_out), .reference_resistor_out_oe(ref_oe),
    .temperature_sensor_out(temp_out), .temperature_sensor_out_oe(temp_oe),
    .humidity_sensor_out(hum_out), .humidity_sensor_out_oe(hum_oe),
    .stop_flag(stop_flag), .counting_window(counting_window),
    .timer_zero_irq(timer_zero_irq));

  rfc_osc_model rfc_osc_model_i (.ref_out(ref_out), .ref_oe(ref_oe), .temp_out(temp_out),
    .temp_oe(temp_oe), .hum_out(hum_out), .hum_oe(hum_oe), .cx(cx));

  ////////////////////////////////////////////////////////////////////////////////
  // access tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({16'h0, d}, {16'h0, exp});
  endtask
  task automatic rcnt(output logic [23:0] v);
    rd(REG_T0_DATA, v[7:0]);
    rd(REG_T1_DATA, v[15:8]);
    rd(REG_T2_DATA, v[23:16]);
  endtask
  task automatic wait_win(input logic lvl, input int limit);
    int t;
    t = 0;
    while (counting_window !== lvl && t < limit) begin
      @(posedge clk);
      #1 t++;
    end
    #1 chk({23'h0, counting_window}, {23'h0, lvl});
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one measurement in a given stop mode, width and preload
  task automatic measure(input logic [1:0] mode, input logic [7:0] en,
                         input logic [23:0] pre, input logic irq_on);
    logic [23:0] mask, v, v2;
    logic [7:0]  last;
    int          n, diff;
    last = (mode == 2'h1) ? 8'h04 : 8'h01;
    if (mode == 2'h2) mask = en[2] ? 24'hffffff : (en[1] ? 24'h00ffff : 24'h0000ff);
    else mask = en[1] ? 24'h00ffff : 24'h0000ff;
    wr(REG_NETWORK, 8'h10);
    wr(REG_TIMER0_CONTROL, {mode, 6'h00});
    wr(REG_WINDOW_TIMER, 8'h06);
    wr(REG_T0_DATA, pre[7:0]);
    wr(REG_T1_DATA, pre[15:8]);
    wr(REG_T2_DATA, pre[23:16]);
    wr(REG_IRQ_ENABLE, {5'h00, irq_on, 2'h0});
    wr(REG_TIMER_ENABLE, en & ~last);
    repeat (4) @(posedge clk);
    #1 chk({23'h0, counting_window}, 24'h0);
    n_t0 = 0;
    n_cx = 0;
    n_win = 0;
    wr(REG_TIMER_ENABLE, en);
    wait_win(1'b1, 3000);
    wait_win(1'b0, 9000);
    chk({23'h0, stop_flag}, 24'h1);
    repeat (2) @(posedge clk);
    #1 chk({23'h0, timer_zero_irq}, {23'h0, irq_on});
    n = (mode == 2'h2) ? n_t0 : n_cx;
    rcnt(v);
    diff = int'((pre - v) & mask) - n;
    chk({23'h0, diff >= -2 && diff <= 2}, 24'h1);
    chk(v & ~mask, pre & ~mask);
    if (mode == 2'h1) begin
      chk({23'h0, n_win >= 2 && n_win <= 6}, 24'h1);
      rchk(REG_WINDOW_TIMER, WINDOW_ZERO);
    end
    repeat (40) @(posedge clk);
    rcnt(v2);
    chk(v2, v);
    rchk(REG_STATUS, 8'h01);
    wr(REG_STATUS, 8'h01);
    wr(REG_TIMER_ENABLE, 8'h00);
    #1 chk({22'h0, stop_flag, timer_zero_irq}, 24'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] regs [9];
    logic       v;
    logic [7:0] d0;
    int         t, diff0;
    regs = '{8'h01, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36};
    bus = '0;
    resetn = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    foreach (regs[i]) rchk(regs[i], BYTE_RESET);
    chk({19'h0, ref_oe, temp_oe, hum_oe, stop_flag, timer_zero_irq}, 24'h0);
    wr(8'h02, 8'h5a);
    rchk(8'h02, 8'h00);
    wr(REG_TIMER0_CONTROL, 8'hff);
    rchk(REG_TIMER0_CONTROL, 8'hff);
    wr(REG_TIMER0_CONTROL, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(REG_NETWORK, {2'h0, 2'(s), 4'h0});
      rchk(REG_NETWORK, {2'h0, 2'(s), 4'h0});
      t = 0;
      v = cx;
      while (cx === v && t < 400) begin
        @(posedge clk);
        t++;
      end
      repeat (8) @(posedge clk);
      #1 chk({21'h0, hum_oe, temp_oe, ref_oe}, (s == 0) ? 24'h0 : 24'h1 << (s - 1));
      if (s != 0) chk({23'h0, s == 1 ? ref_out : (s == 2 ? temp_out : hum_out)},
                      {23'h0, ~cx});
    end
    n_t0 = 0;
    wr(REG_T0_DATA, 8'hc0);
    wr(REG_TIMER_ENABLE, 8'h01);
    wait_win(1'b1, 8);
    repeat (100) @(posedge clk);
    wr(REG_TIMER_ENABLE, 8'h00);
    @(posedge clk);
    #1 chk({23'h0, counting_window}, 24'h0);
    rd(REG_T0_DATA, d0);
    diff0 = int'(8'hc0 - d0) - n_t0;
    chk({23'h0, diff0 >= -2 && diff0 <= 2 && n_t0 > 10}, 24'h1);
    measure(2'h2, 8'h03, 24'h00ffff, 1'b1);
    measure(2'h2, 8'h07, 24'h010005, 1'b0);
    measure(2'h2, 8'h01, 24'h5a3480, 1'b1);
    measure(2'h3, 8'h03, 24'h000100, 1'b1);
    measure(2'h1, 8'h07, 24'h770200, 1'b0);
    end_sim();
  end

  initial begin
    #(40 * 40000);
    miscompares++;
    end_sim();
  end
endmodule
